// file: hdl/acd_pkg.sv
// shared constants and types of the analog channel configuration decoder
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
package acd_pkg;

	localparam int ACD_NUM_IN  = 4;
	localparam int ACD_NUM_OUT = 2;

	// register map, byte addresses
	localparam logic [7:0] ACD_CFG_BASE = 8'h00;
	localparam logic [7:0] ACD_STATUS   = 8'h40;
	localparam logic [7:0] ACD_IRQ_EN   = 8'h44;
	localparam logic [7:0] ACD_IRQ_CLR  = 8'h48;
	localparam logic [7:0] ACD_ERR      = 8'h4c;
	localparam logic [7:0] ACD_INFO     = 8'h50;
	localparam int         ACD_ERR_ANY  = 31;

	// field layout of the configuration words
	localparam int ACD_FILT_LSB = 0;
	localparam int ACD_FILT_W   = 4;
	localparam int ACD_TYPE_LSB = 0;
	localparam int ACD_TYPE_W   = 6;
	localparam int ACD_FMT_LSB  = 8;
	localparam int ACD_FMT_W    = 3;

	localparam logic [31:0] ACD_FILT_MASK = 32'h0000000f;
	localparam logic [31:0] ACD_CFG_MASK  = 32'h0000073f;
	localparam logic [31:0] ACD_WORD_RST  = 32'h00000000;

	// highest legal codes
	localparam logic [3:0] ACD_FILT_MAX  = 4'h5;
	localparam logic [2:0] ACD_IFMT_MAX  = 3'h4;
	localparam logic [2:0] ACD_OFMT_MAX  = 3'h3;
	localparam logic [5:0] ACD_ITYPE_MAX = 6'h20;

	// input type code boundaries
	localparam logic [5:0] ACD_TC_FIRST  = 6'h08;
	localparam logic [5:0] ACD_TC_LAST   = 6'h10;
	localparam logic [5:0] ACD_RTD_LAST  = 6'h1c;
	localparam logic [5:0] ACD_MV_FIRST  = 6'h06;
	localparam logic [5:0] ACD_I_4_20    = 6'h03;
	localparam logic [5:0] ACD_I_0_20    = 6'h05;

	// filter corner frequencies in hz
	localparam logic [10:0] ACD_HZ_60   = 11'h03c;
	localparam logic [10:0] ACD_HZ_50   = 11'h032;
	localparam logic [10:0] ACD_HZ_10   = 11'h00a;
	localparam logic [10:0] ACD_HZ_250  = 11'h0fa;
	localparam logic [10:0] ACD_HZ_500  = 11'h1f4;
	localparam logic [10:0] ACD_HZ_1000 = 11'h3e8;

	typedef enum logic [1:0] {
		ACD_K_FILT = 2'h0,
		ACD_K_IN   = 2'h1,
		ACD_K_OUT  = 2'h2
	} acd_kind_t;

	typedef enum logic [2:0] {
		ACD_C_VOLT = 3'h0,
		ACD_C_CURR = 3'h1,
		ACD_C_MV   = 3'h2,
		ACD_C_TC   = 3'h3,
		ACD_C_RTD  = 3'h4,
		ACD_C_OHM  = 3'h5
	} acd_class_t;

endpackage

// file: hdl/acd_chk_if.sv
// carries one candidate configuration word to its checker and the verdict back
// assumes the checker is purely combinational
`timescale 1ns/1ns
interface acd_chk_if;
	import acd_pkg::*;
	logic [31:0] word;
	acd_kind_t   kind;
	logic        ok;
	modport src (output word, output kind, input ok);
	modport chk (input word, input kind, output ok);
endinterface

// file: hdl/acd_word_chk.sv
// legality check of one configuration word, by word kind
// assumes kind is constant per instance
`timescale 1ns/1ns
module acd_word_chk
	import acd_pkg::*;
(
	acd_chk_if.chk c
);

	logic [ACD_FILT_W-1:0] filt;
	logic [ACD_FMT_W-1:0]  fmt;
	logic [ACD_TYPE_W-1:0] typ;

	assign filt = c.word[ACD_FILT_LSB +: ACD_FILT_W];
	assign fmt  = c.word[ACD_FMT_LSB +: ACD_FMT_W];
	assign typ  = c.word[ACD_TYPE_LSB +: ACD_TYPE_W];

	always_comb
	begin
		unique case (c.kind)
			ACD_K_FILT: c.ok = ((c.word & ~ACD_FILT_MASK) == 32'h0) // R5
				&& (filt <= ACD_FILT_MAX); // R2
			ACD_K_IN:   c.ok = ((c.word & ~ACD_CFG_MASK) == 32'h0)
				&& (fmt <= ACD_IFMT_MAX) // R4
				&& (typ <= ACD_ITYPE_MAX);
			// output type/range is stored but not judged here
			ACD_K_OUT:  c.ok = ((c.word & ~ACD_CFG_MASK) == 32'h0)
				&& (fmt <= ACD_OFMT_MAX); // R4
			default:    c.ok = 1'b0;
		endcase
	end

endmodule

// file: hdl/acd_irq.sv
// sticky event status, enable mask and level interrupt
// assumes event pulses and write strobes are one cycle, same clock
`timescale 1ns/1ns
module acd_irq
#(
	parameter int W = 10
)
(
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] event_set,
	input  wire logic         en_we,
	input  wire logic         clr_we,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] status,
	output logic      [W-1:0] enable,
	output logic              irq
);

	// a new event outranks a clear written in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			status <= '0;
		else
			status <= (status & ~(clr_we ? wdata : '0)) | event_set;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			enable <= '0;
		else if (en_we)
			enable <= wdata;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= |(next_masked());
	end

	function automatic logic [W-1:0] next_masked();
		next_masked = ((status & ~(clr_we ? wdata : '0)) | event_set)
			& (en_we ? wdata : enable);
	endfunction

endmodule

// file: hdl/acd_cfg_decoder.sv
// analog channel configuration decoder: apb register bank that checks and
// decodes per-channel filter, format and sensor type words
// assumes a single 250 mhz clock, synchronous active-high reset, apb master
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns

// What this block does
// (R1) the low four bits of an input filter word pick 60, 50, 10, 250, 500 hz or 1 khz for codes 0 to 5.
// (R2) a filter code above five or any set unused bit gives a module configuration error.
// (R3) bits 8 to 10 of an input word pick raw, engineering, engineering x10, pid scaled or percent.
// (R4) format codes 5 to 7 on inputs and 4 to 7 on outputs give a module configuration error.
// (R5) software writes zero into every bit the encodings show as zero.
// (R6) input type codes 0 to 7 pick the voltage, current and millivolt ranges.
// (R7) input type codes 8 to 15 pick thermocouples j k t e r s b n, and code 16 picks type c.
// (R8) input type codes 17 to 32 pick the rtd sensors and then the plain resistance ranges.
// (R9) bits 8 to 10 of an output word pick raw, engineering, pid scaled or percent.
// (R10) an error stands until a valid word is written, and a bad word leaves the settings alone.
module acd_cfg_decoder
	import acd_pkg::*;
#(
	parameter int NUM_IN  = ACD_NUM_IN,
	parameter int NUM_OUT = ACD_NUM_OUT
)
(
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	output logic                          irq,
	output logic                          cfg_error,
	output logic [NUM_IN-1:0][10:0]       in_filter_hz,
	output logic [NUM_IN-1:0][2:0]        in_format,
	output logic [NUM_IN-1:0][5:0]        in_type,
	output logic [NUM_IN-1:0][2:0]        in_class,
	output logic [NUM_IN-1:0][3:0]        in_sub,
	output logic [NUM_OUT-1:0][2:0]       out_format,
	output logic [NUM_OUT-1:0][5:0]       out_type
);

	localparam int NW = 2 * NUM_IN + NUM_OUT;

	logic [31:0]   active [NW];
	logic [NW-1:0] word_ok;
	logic [NW-1:0] word_sel;
	logic [NW-1:0] word_err;
	logic [NW-1:0] reject_ev;
	logic [NW-1:0] irq_status;
	logic [NW-1:0] irq_enable;
	logic          setup;
	logic          wr_acc;
	logic          cfg_hit;
	logic [5:0]    widx;
	logic [31:0]   next_prdata;
	logic          next_pslverr;

	// filter word code to corner frequency
	function automatic logic [10:0] filt_hz(input logic [3:0] code);
		unique case (code)
			4'h0:    filt_hz = ACD_HZ_60;
			4'h1:    filt_hz = ACD_HZ_50;
			4'h2:    filt_hz = ACD_HZ_10;
			4'h3:    filt_hz = ACD_HZ_250;
			4'h4:    filt_hz = ACD_HZ_500;
			4'h5:    filt_hz = ACD_HZ_1000;
			default: filt_hz = ACD_HZ_60;
		endcase
	endfunction

	// input type code to sensor class
	function automatic acd_class_t type_class(input logic [5:0] code);
		if (code < ACD_MV_FIRST)
			type_class = (code == ACD_I_4_20 || code == ACD_I_0_20) ?
				ACD_C_CURR : ACD_C_VOLT;
		else if (code < ACD_TC_FIRST)
			type_class = ACD_C_MV;
		else if (code <= ACD_TC_LAST)
			type_class = ACD_C_TC;
		else if (code <= ACD_RTD_LAST)
			type_class = ACD_C_RTD;
		else
			type_class = ACD_C_OHM;
	endfunction

	// index of the range within its class: tc j..c 0..8, rtd 0..11, ohm 0..3
	function automatic logic [3:0] type_sub(input logic [5:0] code);
		logic [5:0] d;
		d = 6'h00;
		if (code >= ACD_TC_FIRST && code <= ACD_TC_LAST)
			d = code - ACD_TC_FIRST;
		else if (code > ACD_TC_LAST && code <= ACD_RTD_LAST)
			d = code - ACD_TC_LAST - 6'h01;
		else if (code > ACD_RTD_LAST)
			d = code - ACD_RTD_LAST - 6'h01;
		else
			d = code;
		type_sub = d[3:0];
	endfunction

	// zero-wait slave: read data is caught in the setup cycle
	assign pready = 1'b1;
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign widx   = paddr[7:2];
	assign cfg_hit = (paddr[1:0] == 2'h0) && (widx < 6'(NW));

	generate
		for (genvar i = 0; i < NW; i++)
		begin : g_word
			localparam acd_kind_t KIND = (i >= 2 * NUM_IN) ? ACD_K_OUT :
				((i % 2) == 1) ? ACD_K_IN : ACD_K_FILT;

			acd_chk_if c ();

			assign c.word     = pwdata;
			assign c.kind     = KIND;
			assign word_ok[i] = c.ok;
			assign word_sel[i] = wr_acc && cfg_hit && (widx == 6'(i));
			assign reject_ev[i] = word_sel[i] & ~word_ok[i]; // R2

			acd_word_chk u_chk (
				.c (c)
			);

			// a rejected word never reaches the active settings
			always_ff @(posedge sys_clk)
			begin
				if (reset)
					active[i] <= ACD_WORD_RST;
				else if (word_sel[i] && word_ok[i]) // R10
					active[i] <= pwdata;
			end

			// error tracks the last write to this word
			always_ff @(posedge sys_clk)
			begin
				if (reset)
					word_err[i] <= 1'b0;
				else if (word_sel[i])
					word_err[i] <= ~word_ok[i]; // R10
			end
		end
	endgenerate

	// module condition summary
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			cfg_error <= 1'b0;
		else
			cfg_error <= |((word_err & ~word_sel) | reject_ev); // R4
	end

	generate
		for (genvar j = 0; j < NUM_IN; j++)
		begin : g_in
			always_ff @(posedge sys_clk)
			begin
				if (reset)
				begin
					in_filter_hz[j] <= ACD_HZ_60;
					in_format[j]    <= 3'h0;
					in_type[j]      <= 6'h00;
					in_class[j]     <= ACD_C_VOLT;
					in_sub[j]       <= 4'h0;
				end
				else
				begin
					in_filter_hz[j] <= filt_hz(active[2*j][ACD_FILT_LSB +: ACD_FILT_W]); // R1
					in_format[j]    <= active[2*j+1][ACD_FMT_LSB +: ACD_FMT_W]; // R3
					in_type[j]      <= active[2*j+1][ACD_TYPE_LSB +: ACD_TYPE_W]; // R6
					in_class[j]     <= type_class(active[2*j+1][ACD_TYPE_LSB +: ACD_TYPE_W]); // R7
					in_sub[j]       <= type_sub(active[2*j+1][ACD_TYPE_LSB +: ACD_TYPE_W]); // R8
				end
			end
		end

		for (genvar k = 0; k < NUM_OUT; k++)
		begin : g_out
			always_ff @(posedge sys_clk)
			begin
				if (reset)
				begin
					out_format[k] <= 3'h0;
					out_type[k]   <= 6'h00;
				end
				else
				begin
					out_format[k] <= active[2*NUM_IN+k][ACD_FMT_LSB +: ACD_FMT_W]; // R9
					out_type[k]   <= active[2*NUM_IN+k][ACD_TYPE_LSB +: ACD_TYPE_W];
				end
			end
		end
	endgenerate

	acd_irq #(
		.W (NW)
	) u_irq (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.event_set (reject_ev),
		.en_we     (wr_acc && paddr == ACD_IRQ_EN),
		.clr_we    (wr_acc && paddr == ACD_IRQ_CLR),
		.wdata     (pwdata[NW-1:0]),
		.status    (irq_status),
		.enable    (irq_enable),
		.irq       (irq)
	);

	// read mux, decoded from the setup-cycle address
	always_comb
	begin
		next_prdata  = 32'h0;
		next_pslverr = 1'b0;
		if (cfg_hit)
			next_prdata = active[widx[$clog2(NW)-1:0]];
		else
		begin
			unique case (paddr)
				ACD_STATUS:  next_prdata = 32'(irq_status);
				ACD_IRQ_EN:  next_prdata = 32'(irq_enable);
				ACD_IRQ_CLR: next_prdata = 32'h0;
				ACD_ERR:
				begin
					next_prdata = 32'(word_err);
					next_prdata[ACD_ERR_ANY] = |word_err;
				end
				ACD_INFO:    next_prdata = {16'(NUM_OUT), 16'(NUM_IN)};
				default:     next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= pwrite ? 32'h0 : next_prdata;
			pslverr <= next_pslverr;
		end
	end

endmodule

// file: test/acd_cfg_checker.sv
// port-level relations of the configuration decoder
// assumes the decoder's own ports only; bound after the module
`timescale 1ns/1ns
module acd_cfg_checker
	import acd_pkg::*;
#(
	parameter int NUM_IN  = 4,
	parameter int NUM_OUT = 2
)
(
	input wire logic                 sys_clk,
	input wire logic                 reset,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic                 irq,
	input wire logic                 cfg_error,
	input wire logic [NUM_IN-1:0][10:0] in_filter_hz,
	input wire logic [NUM_IN-1:0][2:0]  in_format,
	input wire logic [NUM_IN-1:0][5:0]  in_type,
	input wire logic [NUM_IN-1:0][2:0]  in_class,
	input wire logic [NUM_OUT-1:0][2:0] out_format
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire wr  = psel && penable && pwrite;
	wire wr0 = wr && paddr == 8'h00;

	a_filt_good: assert property (wr0 && pwdata == 32'h3 |-> ##2 in_filter_hz[0] == 11'h0fa)
		else $error("filter code 3 not decoded");
	a_filt_bad: assert property (wr0 && pwdata > 32'h5 |-> ##2 cfg_error)
		else $error("bad filter word not flagged");
	a_bad_keeps: assert property (wr0 && pwdata > 32'h5 |-> ##1 $stable(in_filter_hz[0]) [*2])
		else $error("bad filter word changed setting");
	a_err_holds: assert property (cfg_error && !wr && !$past(wr) |=> cfg_error)
		else $error("error dropped without a write");
	a_ifmt_follow: assert property (wr && paddr == 8'h04 && pwdata == 32'h300
		|-> ##2 in_format[0] == 3'h3)
		else $error("input format not decoded");
	a_ifmt_range: assert property (in_format[0] <= 3'h4)
		else $error("input format out of range");
	a_ofmt_range: assert property (out_format[0] <= 3'h3)
		else $error("output format out of range");
	a_volt_class: assert property (in_type[0] inside {6'h0, 6'h1, 6'h2, 6'h4}
		|-> in_class[0] == 3'h0)
		else $error("voltage type misclassed");
	a_tc_class: assert property (in_type[0] inside {[6'h08:6'h10]} |-> in_class[0] == 3'h3)
		else $error("thermocouple misclassed");
	a_rtd_class: assert property (in_type[0] inside {[6'h11:6'h1c]} |-> in_class[0] == 3'h4)
		else $error("rtd misclassed");

	c_bad: cover property (wr0 && pwdata > 32'h5);
	c_err: cover property (cfg_error);
	c_irq: cover property (irq);
endmodule

bind acd_cfg_decoder acd_cfg_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) acd_cfg_checker_i (
	.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .irq(irq), .cfg_error(cfg_error),
	.in_filter_hz(in_filter_hz), .in_format(in_format), .in_type(in_type),
	.in_class(in_class), .out_format(out_format));

// file: test/acd_host.sv
// host model: apb master that writes and reads configuration words
// assumes pready is sampled at the access edge, one clock domain
`timescale 1ns/1ns
module acd_host
(
	input  wire logic        sys_clk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	initial
	begin
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 8'h00;
		pwdata  <= 32'h00000000;
	end

	// released address and data are inverted so stale values never pass
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// file: test/acd_cfg_decoder_test.sv
// self-checking bench of the configuration decoder over apb
// assumes the host model and the bound checker
`timescale 1ns/1ns
module acd_cfg_decoder_test;
	import acd_pkg::*;
	logic sys_clk = 0, reset = 1, psel, penable, pwrite, pready, pslverr, irq, cfg_error, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0][10:0] in_filter_hz;
	logic [3:0][2:0] in_format, in_class;
	logic [3:0][5:0] in_type;
	logic [3:0][3:0] in_sub;
	logic [1:0][2:0] out_format;
	logic [1:0][5:0] out_type;
	logic [6:0] k;
	int fail_count = 0, samples_checked = 0;
	int hz[6] = '{60, 50, 10, 250, 500, 1000};

	always #2 sys_clk = ~sys_clk;

	acd_cfg_decoder acd_cfg_decoder_i (.*);
	acd_host acd_host_i (.*);

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask

	// outputs lag the access edge by one cycle
	task wr(input logic [7:0] a, input logic [31:0] d);
		acd_host_i.xfer(1, a, d, r, e);
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
		acd_host_i.xfer(0, a, 0, r, e);
		check("rdata", r, exp);
		check("slverr", e, eexp);
	endtask

	// {class, index within class} of an input type code
	function automatic logic [6:0] cls(input int t);
		if (t > 28) return {3'h5, 4'(t - 29)};
		if (t > 16) return {3'h4, 4'(t - 17)};
		if (t > 7) return {3'h3, 4'(t - 8)};
		if (t > 5) return {3'h2, 4'(t)};
		if (t == 3 || t == 5) return {3'h1, 4'(t)};
		return {3'h0, 4'(t)};
	endfunction

	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		#80000;
		fail_count++;
		wrap_up;
	end

	initial
	begin
		repeat (2) @(posedge sys_clk);
		reset <= 0;
		#1;
		check("hz", in_filter_hz[0], 60);
		rd(8'h40, 0, 0);
		for (int c = 0; c < 6; c++)
		begin
			wr(8'h00, c);
			check("hz", in_filter_hz[0], hz[c]);
		end
		wr(8'h44, 1);
		rd(8'h44, 1, 0);
		wr(8'h00, 6);
		check("err", cfg_error, 1);
		check("hz", in_filter_hz[0], 1000);
		rd(8'h00, 5, 0);
		rd(8'h4c, 32'h80000001, 0);
		check("irq", irq, 1);
		wr(8'h48, 1);
		check("irq", irq, 0);
		wr(8'h00, 32'h10);
		check("err", cfg_error, 1);
		rd(8'h40, 1, 0);
		wr(8'h00, 0);
		check("err", cfg_error, 0);
		$display("filter test done");
		for (int f = 0; f < 8; f++)
		begin
			wr(8'h04, f << 8);
			check("ifmt", in_format[0], f > 4 ? 4 : f);
			check("ierr", cfg_error, f > 4);
			wr(8'h20, f << 8);
			check("ofmt", out_format[0], f > 3 ? 3 : f);
			check("oerr", cfg_error, f > 3);
		end
		wr(8'h04, 0);
		wr(8'h20, 0);
		wr(8'h20, 32'h205);
		check("ofmt", out_format[0], 2);
		check("otype", out_type[0], 5);
		wr(8'h20, 32'h405);
		check("otype", out_type[0], 5);
		check("oerr", cfg_error, 1);
		wr(8'h20, 0);
		$display("format test done");
		for (int t = 0; t < 34; t++)
		begin
			wr(8'h04, t);
			k = cls(t > 32 ? 32 : t);
			check("type", in_type[0], t > 32 ? 32 : t);
			check("class", in_class[0], k[6:4]);
			check("sub", in_sub[0], k[3:0]);
			check("terr", cfg_error, t > 32);
		end
		$display("type test done");
		rd(8'h50, {16'(ACD_NUM_OUT), 16'(ACD_NUM_IN)}, 0);
		rd(8'h60, 0, 1);
		acd_host_i.xfer(1, 8'h60, 1, r, e);
		check("werr", e, 1);
		$display("map test done");
		wrap_up;
	end
endmodule
